// file: design/wdit_pkg.sv
// Purpose: Shared constants and types for the watchdog and interval timer
// Assumes: 16-bit register port, timer clocks arrive as pins
// Notes: Control field order matches the control word's low byte
package wdit_pkg;

    // ==========================================
    // Register map
    localparam logic [15:0] CTRL_ADDR = 16'h0120;
    localparam logic [15:0] IE_ADDR = 16'h0000;
    localparam logic [15:0] IFG_ADDR = 16'h0002;

    // ==========================================
    // Keys and bit positions
    localparam logic [7:0] WRITE_KEY = 8'h5A;
    localparam logic [7:0] READ_KEY = 8'h69;
    localparam int INT_BIT = 0;
    localparam logic MODE_WATCHDOG = 1'b0;
    localparam logic MODE_INTERVAL = 1'b1;
    localparam logic SSEL_SUB_MAIN = 1'b0;
    localparam logic SSEL_AUX = 1'b1;

    // ==========================================
    // Intervals in timer clock cycles
    localparam int INTERVAL_0 = 32768;
    localparam int INTERVAL_1 = 8192;
    localparam int INTERVAL_2 = 512;
    localparam int INTERVAL_3 = 64;

    // Main clock cycles without a source edge before it counts as failed
    localparam int FAIL_W = 7;
    localparam logic [FAIL_W-1:0] FAIL_LIMIT = 7'h40;

    // ==========================================
    // Types
    typedef struct packed {
        logic hold;
        logic nmi_edge;
        logic nmi_sel;
        logic mode;
        logic cntcl;
        logic ssel;
        logic [1:0] isel;
    } wdit_ctrl_t;

    localparam wdit_ctrl_t CTRL_RESET = 8'h00;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } wdit_bus_t;

    // Last count value of the selected interval
    function automatic logic [15:0] wdit_last(input logic [1:0] isel);
        case (isel)
            2'h0: wdit_last = 16'(INTERVAL_0 - 1);
            2'h1: wdit_last = 16'(INTERVAL_1 - 1);
            2'h2: wdit_last = 16'(INTERVAL_2 - 1);
            default: wdit_last = 16'(INTERVAL_3 - 1);
        endcase
    endfunction

endpackage

// file: design/wdit_tick.sv
// Purpose: Turns the selected timer clock pin into one-cycle count ticks
// Assumes: Timer clocks are slower than mclk
// Notes: Falls back to mclk ticks when the source stops and fallback is allowed
`timescale 1ns/1ps
module wdit_tick (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Timer clock pins
    input wire logic aux_clk_pin,
    input wire logic sub_main_clk_pin,
    // Control
    input wire logic sel_aux,
    input wire logic fail_safe_en,
    // Results
    output logic tick,
    output logic failed
);
    // ==========================================
    // Synchronisers
    logic [1:0] aux_q, aux_d;
    logic [1:0] sub_q, sub_d;
    logic last_q, last_d;
    logic [wdit_pkg::FAIL_W-1:0] idle_q, idle_d;
    logic failed_q, failed_d;
    logic edge_seen;

    always_comb begin
        aux_d = {aux_q[0], aux_clk_pin};
        sub_d = {sub_q[0], sub_main_clk_pin};
        last_d = sel_aux ? aux_q[1] : sub_q[1];
        edge_seen = last_d & ~last_q;
        idle_d = idle_q;
        failed_d = failed_q;
        if (edge_seen) begin
            idle_d = '0;
            failed_d = 1'b0;
        end else if (idle_q == wdit_pkg::FAIL_LIMIT) begin
            failed_d = 1'b1;
        end else begin
            idle_d = idle_q + 1'b1;
        end
        tick = (failed_q & fail_safe_en) ? 1'b1 : edge_seen;
        failed = failed_q;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            aux_q <= 2'h0;
            sub_q <= 2'h0;
            last_q <= 1'b0;
            idle_q <= '0;
            failed_q <= 1'b0;
        end else begin
            aux_q <= aux_d;
            sub_q <= sub_d;
            last_q <= last_d;
            idle_q <= idle_d;
            failed_q <= failed_d;
        end
    end

endmodule // wdit_tick

// file: design/wdit_timer.sv
// Purpose: Watchdog and interval timer behind a password-guarded control word
// Assumes: Plain register port; reset is the power-on reset
// Notes: The power-up-clear pulse also restores the control word, counter and enable defaults
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module wdit_timer (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Register port
    input wire wdit_pkg::wdit_bus_t bus,
    output logic [15:0] rdata_q,
    // Timer clock pins
    input wire logic aux_clk_pin,
    input wire logic sub_main_clk_pin,
    // Processor core
    input wire logic global_int_enable,
    input wire logic irq_ack,
    output logic irq_q,
    // System reset and clock control
    output logic power_up_clear_q,
    output logic nmi_select_q,
    output logic nmi_edge_q,
    output logic clk_keep_on_q,
    output logic clk_fallback_q
);

    // ==========================================
    // State
    wdit_pkg::wdit_ctrl_t ctrl_q, ctrl_d;
    logic [15:0] wd_counter_q, wd_counter_d;
    logic timer_int_enable_q, timer_int_enable_d;
    logic timer_int_flag_q, timer_int_flag_d;
    logic [15:0] rdata_d;
    logic irq_d;
    logic puc_d;
    logic keep_on_d;
    logic fallback_d;

    // ==========================================
    // Decode and events
    logic tick;
    logic src_failed;
    logic wr_ctrl, wr_ie, wr_ifg;
    logic rd_ctrl, rd_ie, rd_ifg;
    logic key_bad;
    logic expire;
    logic flag_set;
    wdit_pkg::wdit_ctrl_t wr_fields;

    wdit_tick u_tick (
        .mclk(mclk),
        .reset(reset),
        .aux_clk_pin(aux_clk_pin),
        .sub_main_clk_pin(sub_main_clk_pin),
        .sel_aux(ctrl_q.ssel == wdit_pkg::SSEL_AUX),
        .fail_safe_en(ctrl_q.mode == wdit_pkg::MODE_WATCHDOG),
        .tick(tick),
        .failed(src_failed)
    );

    always_comb begin
        wr_ctrl = 1'b0;
        wr_ie = 1'b0;
        wr_ifg = 1'b0;
        rd_ctrl = 1'b0;
        rd_ie = 1'b0;
        rd_ifg = 1'b0;
        if (bus.addr == wdit_pkg::CTRL_ADDR) begin
            wr_ctrl = bus.wr;
            rd_ctrl = bus.rd;
        end else if (bus.addr == wdit_pkg::IE_ADDR) begin
            wr_ie = bus.wr;
            rd_ie = bus.rd;
        end else if (bus.addr == wdit_pkg::IFG_ADDR) begin
            wr_ifg = bus.wr;
            rd_ifg = bus.rd;
        end
        wr_fields = wdit_pkg::wdit_ctrl_t'(bus.wdata[7:0]);
        key_bad = wr_ctrl && (bus.wdata[15:8] != wdit_pkg::WRITE_KEY);
        // Reaching or passing the last count expires on the next tick
        expire = tick && !ctrl_q.hold
            && (wd_counter_q >= wdit_pkg::wdit_last(ctrl_q.isel));
    end

    // ==========================================
    // Control word, counter and power-up-clear
    always_comb begin
        ctrl_d = ctrl_q;
        wd_counter_d = wd_counter_q;
        puc_d = 1'b0;
        if (wr_ctrl && !key_bad) begin
            ctrl_d = wr_fields;
            ctrl_d.cntcl = 1'b0;
        end
        if (tick && !ctrl_q.hold) begin
            wd_counter_d = expire ? 16'h0000 : wd_counter_q + 16'h0001;
        end
        if (wr_ctrl && !key_bad && wr_fields.cntcl) begin
            wd_counter_d = 16'h0000;
        end
        if (key_bad) begin
            puc_d = 1'b1;
        end
        if (expire && ctrl_q.mode == wdit_pkg::MODE_WATCHDOG) begin
            puc_d = 1'b1;
        end
        if (power_up_clear_q) begin
            ctrl_d = wdit_pkg::CTRL_RESET;
            wd_counter_d = 16'h0000;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl_q <= wdit_pkg::CTRL_RESET;
            wd_counter_q <= 16'h0000;
            power_up_clear_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            wd_counter_q <= wd_counter_d;
            power_up_clear_q <= puc_d;
        end
    end

    // ==========================================
    // Interrupt enable and flag
    always_comb begin
        timer_int_enable_d = timer_int_enable_q;
        if (wr_ie) begin
            timer_int_enable_d = bus.wdata[wdit_pkg::INT_BIT];
        end
        if (power_up_clear_q) begin
            timer_int_enable_d = 1'b0;
        end
        // Interval expiry sets the flag; watchdog causes set it too
        flag_set = puc_d || (expire && ctrl_q.mode == wdit_pkg::MODE_INTERVAL);
        timer_int_flag_d = timer_int_flag_q;
        if (irq_ack && ctrl_q.mode == wdit_pkg::MODE_INTERVAL) begin
            timer_int_flag_d = 1'b0;
        end
        if (wr_ifg) begin
            timer_int_flag_d = bus.wdata[wdit_pkg::INT_BIT];
        end
        if (flag_set) begin
            timer_int_flag_d = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            timer_int_enable_q <= 1'b0;
            timer_int_flag_q <= 1'b0;
        end else begin
            timer_int_enable_q <= timer_int_enable_d;
            timer_int_flag_q <= timer_int_flag_d;
        end
    end

    // ==========================================
    // Outputs and read data
    always_comb begin
        // Watchdog-mode flag goes to the reset vector, not this request
        irq_d = timer_int_flag_d && timer_int_enable_d && global_int_enable
            && ctrl_d.mode == wdit_pkg::MODE_INTERVAL;
        keep_on_d = ctrl_d.mode == wdit_pkg::MODE_WATCHDOG;
        fallback_d = src_failed && ctrl_q.mode == wdit_pkg::MODE_WATCHDOG;
        rdata_d = 16'h0000;
        if (rd_ctrl) begin
            rdata_d = {wdit_pkg::READ_KEY, ctrl_q};
        end else if (rd_ie) begin
            rdata_d[wdit_pkg::INT_BIT] = timer_int_enable_q;
        end else if (rd_ifg) begin
            rdata_d[wdit_pkg::INT_BIT] = timer_int_flag_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_q <= 1'b0;
            clk_keep_on_q <= 1'b1;
            clk_fallback_q <= 1'b0;
            rdata_q <= 16'h0000;
            nmi_select_q <= 1'b0;
            nmi_edge_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
            clk_keep_on_q <= keep_on_d;
            clk_fallback_q <= fallback_d;
            rdata_q <= rdata_d;
            nmi_select_q <= ctrl_d.nmi_sel;
            nmi_edge_q <= ctrl_d.nmi_edge;
        end
    end

    // ==========================================
    // Assertions
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    sequence s_bad_write;
        bus.wr && bus.addr == wdit_pkg::CTRL_ADDR
            && bus.wdata[15:8] != wdit_pkg::WRITE_KEY;
    endsequence

    sequence s_puc_then_default;
        power_up_clear_q ##1 (ctrl_q == wdit_pkg::CTRL_RESET
            && wd_counter_q == 16'h0000 && !nmi_select_q);
    endsequence

    property p_key_puc;
        s_bad_write |=> power_up_clear_q ##0 timer_int_flag_q;
    endproperty
    a_key_puc: assert property (p_key_puc)
        else $error("bad key did not raise power-up-clear");

    property p_read_key;
        bus.rd && bus.addr == wdit_pkg::CTRL_ADDR
            |=> rdata_q[15:8] == wdit_pkg::READ_KEY && !rdata_q[3];
    endproperty
    a_read_key: assert property (p_read_key)
        else $error("control word read lacks fixed key");

    property p_puc_default;
        power_up_clear_q |-> s_puc_then_default;
    endproperty
    a_puc_default: assert property (p_puc_default)
        else $error("power-up-clear did not restore defaults");

    property p_wd_expire;
        expire && ctrl_q.mode == wdit_pkg::MODE_WATCHDOG |=> power_up_clear_q;
    endproperty
    a_wd_expire: assert property (p_wd_expire)
        else $error("watchdog expiry without power-up-clear");

    property p_int_expire;
        expire && ctrl_q.mode == wdit_pkg::MODE_INTERVAL && !bus.wr && !power_up_clear_q
            |=> timer_int_flag_q && !power_up_clear_q
            && $stable(timer_int_enable_q);
    endproperty
    a_int_expire: assert property (p_int_expire)
        else $error("interval expiry handled wrongly");

    property p_irq;
        timer_int_flag_q && timer_int_enable_q && global_int_enable
            && ctrl_q.mode == wdit_pkg::MODE_INTERVAL && !bus.wr
            && !irq_ack && !power_up_clear_q |=> irq_q;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt request missing");

    property p_hold;
        ctrl_q.hold && !power_up_clear_q && !bus.wr |=> $stable(wd_counter_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("counter moved while halted");

    property p_clear;
        bus.wr && bus.addr == wdit_pkg::CTRL_ADDR
            && bus.wdata[15:8] == wdit_pkg::WRITE_KEY && bus.wdata[3]
            |=> wd_counter_q == 16'h0000 && !ctrl_q.cntcl;
    endproperty
    a_clear: assert property (p_clear)
        else $error("counter clear not applied");

    property p_keep_on;
        clk_keep_on_q == (ctrl_q.mode == wdit_pkg::MODE_WATCHDOG);
    endproperty
    a_keep_on: assert property (p_keep_on)
        else $error("timer clock not kept on in watchdog mode");

    sequence s_serviced;
        irq_ack && ctrl_q.mode == wdit_pkg::MODE_INTERVAL && !expire && !bus.wr;
    endsequence

    property p_ack_clear;
        s_serviced |=> !timer_int_flag_q && !irq_q;
    endproperty
    a_ack_clear: assert property (p_ack_clear)
        else $error("serviced interrupt flag not cleared");

    property p_ie_write;
        bus.wr && bus.addr == wdit_pkg::IE_ADDR && !power_up_clear_q
            |=> timer_int_enable_q == $past(bus.wdata[wdit_pkg::INT_BIT]);
    endproperty
    a_ie_write: assert property (p_ie_write)
        else $error("interrupt enable write not stored");

    property p_count;
        tick && !ctrl_q.hold && !expire && !bus.wr && !power_up_clear_q
            |=> wd_counter_q == $past(wd_counter_q) + 16'h0001;
    endproperty
    a_count: assert property (p_count)
        else $error("counter did not advance on a tick");

    property p_expire_wrap;
        expire |=> wd_counter_q == 16'h0000;
    endproperty
    a_expire_wrap: assert property (p_expire_wrap)
        else $error("counter did not restart after expiry");

    property p_fallback;
        src_failed && ctrl_q.mode == wdit_pkg::MODE_WATCHDOG |=> clk_fallback_q;
    endproperty
    a_fallback: assert property (p_fallback)
        else $error("failed source did not fall back to main clock");

    property p_no_fallback;
        ctrl_q.mode == wdit_pkg::MODE_INTERVAL |=> !clk_fallback_q;
    endproperty
    a_no_fallback: assert property (p_no_fallback)
        else $error("fallback active in interval mode");

    property p_puc_enable;
        power_up_clear_q |=> !timer_int_enable_q && !irq_q && clk_keep_on_q;
    endproperty
    a_puc_enable: assert property (p_puc_enable)
        else $error("power-up-clear left enable or request set");

endmodule // wdit_timer

// file: bench/wdit_core_model.sv
// Purpose: Processor core and clock system as seen by the timer
// Assumes: Timer clocks are divided down from mclk
// Notes: A stopped clock pin stands still; one acknowledge per request
`timescale 1ns/1ps
module wdit_core_model #(
    parameter int SUB_HALF = 2,
    parameter int AUX_HALF = 4
) (
    // Clock
    input wire logic mclk,
    // Test controls
    input wire logic sub_stop,
    input wire logic ack_en,
    // Timer side
    input wire logic irq_q,
    output logic aux_clk_pin,
    output logic sub_main_clk_pin,
    output logic irq_ack
);
    int sub_n = 0;
    int aux_n = 0;
    logic sub_q = 1'h0;
    logic aux_q = 1'h0;
    logic ack_q = 1'h0;
    logic ack_d = 1'h0;
    assign sub_main_clk_pin = sub_q;
    assign aux_clk_pin = aux_q;
    assign irq_ack = ack_q;
    // ==========================================
    // Divided timer clocks and interrupt service
    always @(posedge mclk) begin
        if (!sub_stop) begin
            sub_n <= (sub_n + 1) % SUB_HALF;
            if (sub_n == SUB_HALF - 1) begin
                sub_q <= ~sub_q;
            end
        end
        aux_n <= (aux_n + 1) % AUX_HALF;
        if (aux_n == AUX_HALF - 1) begin
            aux_q <= ~aux_q;
        end
        // Lockout keeps a request still in flight from being served twice
        ack_q <= ack_en && irq_q && !ack_q && !ack_d;
        ack_d <= ack_q;
    end
endmodule // wdit_core_model

// file: bench/wdit_timer_tb_top.sv
// Purpose: Self-checking bench for the watchdog and interval timer
// Assumes: Sub-main clock period 4 mclk, auxiliary 8 mclk
// Notes: Fallback ticks every mclk make the long intervals affordable
`timescale 1ns/1ps
module wdit_timer_tb_top;
    localparam logic [15:0] CA = wdit_pkg::CTRL_ADDR;
    localparam logic [15:0] EA = wdit_pkg::IE_ADDR;
    localparam logic [15:0] FA = wdit_pkg::IFG_ADDR;
    localparam logic [7:0] CFG [3] = '{8'h1B, 8'h1A, 8'h1F};
    localparam int IVL [3] = '{64, 512, 64};
    localparam int PER [3] = '{4, 4, 8};
    localparam int IV_SEL [4] = '{32768, 8192, 512, 64};
    logic mclk = 1'h0;
    logic reset = 1'h1;
    wdit_pkg::wdit_bus_t bus = '0;
    logic global_int_enable = 1'h0;
    logic sub_stop = 1'h0;
    logic ack_en = 1'h0;
    logic [15:0] rdata_q;
    logic aux_clk_pin, sub_main_clk_pin, irq_ack, irq_q, power_up_clear_q;
    logic nmi_select_q, nmi_edge_q, clk_keep_on_q, clk_fallback_q;
    int n_fail = 0;
    int checks = 0;
    int puc_seen = 0;
    int puc_n;
    int n;

    always #25 mclk = ~mclk;

    wdit_timer wdit_timer_i (.mclk(mclk), .reset(reset), .bus(bus), .rdata_q(rdata_q),
        .aux_clk_pin(aux_clk_pin), .sub_main_clk_pin(sub_main_clk_pin),
        .global_int_enable(global_int_enable), .irq_ack(irq_ack), .irq_q(irq_q),
        .power_up_clear_q(power_up_clear_q), .nmi_select_q(nmi_select_q),
        .nmi_edge_q(nmi_edge_q), .clk_keep_on_q(clk_keep_on_q),
        .clk_fallback_q(clk_fallback_q));

    wdit_core_model wdit_core_model_i (.mclk(mclk), .sub_stop(sub_stop), .ack_en(ack_en),
        .irq_q(irq_q), .aux_clk_pin(aux_clk_pin), .sub_main_clk_pin(sub_main_clk_pin),
        .irq_ack(irq_ack));

    always @(posedge mclk) begin
        if (power_up_clear_q === 1'h1) begin
            puc_seen <= puc_seen + 1;
        end
    end

    // ==========================================
    // Bus, wait and compare tasks
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk);
        bus.wr <= 1'h1;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge mclk);
        bus.wr <= 1'h0;
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chkn(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("mismatch at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
        @(posedge mclk);
        bus.rd <= 1'h1;
        bus.addr <= a;
        @(posedge mclk);
        bus.rd <= 1'h0;
        @(posedge mclk);
        chk16(rdata_q, exp);
    endtask

    task automatic idle(input int c);
        repeat (c) @(posedge mclk);
    endtask

    task automatic wait_hi(input bit use_irq, input int limit, output int cyc);
        cyc = 0;
        do begin
            @(posedge mclk);
            cyc++;
        end while (((use_irq ? irq_q : power_up_clear_q) !== 1'h1) && cyc < limit);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #(70000 * 50);
        n_fail++;
        $display("mismatch at %0t: run did not finish", $time);
        final_report();
    end

    // ==========================================
    // Tests
    initial begin
        idle(5);
        reset <= 1'h0;
        idle(1);
        rdchk(CA, 16'h6900);
        rdchk(EA, 16'h0000);
        rdchk(FA, 16'h0000);
        rdchk(16'h0044, 16'h0000);
        chk1(clk_keep_on_q, 1'h1);
        $display("test defaults done");
        wr(CA, 16'h5AFF);
        rdchk(CA, 16'h69F7);
        chk1(nmi_select_q, 1'h1);
        chk1(nmi_edge_q, 1'h1);
        chk1(clk_keep_on_q, 1'h0);
        $display("test readback done");
        for (int i = 0; i < 3; i++) begin
            wr(EA, 16'h0001);
            global_int_enable <= 1'h1;
            wr(CA, {8'h5A, 8'h80 | (CFG[i] & 8'h04)});
            puc_n = puc_seen;
            wr(CA, {8'h5A, CFG[i]});
            wait_hi(1'h1, IVL[i] * PER[i] + 40, n);
            chkn(n, IVL[i] * PER[i] - PER[i], IVL[i] * PER[i] + PER[i] + 6);
            chkn(puc_seen, puc_n, puc_n);
            rdchk(EA, 16'h0001);
            rdchk(FA, 16'h0001);
            global_int_enable <= 1'h0;
            idle(3);
            chk1(irq_q, 1'h0);
            global_int_enable <= 1'h1;
            idle(3);
            chk1(irq_q, 1'h1);
            if (i == 0) begin
                wr(FA, 16'h0000);
            end else begin
                ack_en <= 1'h1;
                idle(4);
                ack_en <= 1'h0;
            end
            idle(3);
            chk1(irq_q, 1'h0);
            rdchk(FA, 16'h0000);
        end
        $display("test interval done");
        wr(CA, 16'h5A9F);
        idle(600);
        rdchk(FA, 16'h0000);
        $display("test hold done");
        wr(CA, 16'h5A24);
        idle(2);
        chk1(nmi_select_q, 1'h1);
        wr(CA, 16'hA520);
        wait_hi(1'h0, 8, n);
        chkn(n, 1, 2);
        idle(2);
        chk1(nmi_select_q, 1'h0);
        rdchk(CA, 16'h6900);
        rdchk(EA, 16'h0000);
        rdchk(FA, 16'h0001);
        wr(FA, 16'h0000);
        $display("test key done");
        sub_stop <= 1'h1;
        wr(CA, 16'h5A1B);
        idle(600);
        chk1(clk_fallback_q, 1'h0);
        rdchk(FA, 16'h0000);
        $display("test no fail-safe done");
        for (int i = 3; i > 0; i--) begin
            wr(CA, {8'h5A, 6'h02, i[1:0]});
            wait_hi(1'h0, IV_SEL[i] + 100, n);
            chkn(n, IV_SEL[i] - 2, IV_SEL[i] + 70);
            chk1(clk_fallback_q, 1'h1);
        end
        wait_hi(1'h0, 33000, n);
        chkn(n, 32766, 32838);
        rdchk(FA, 16'h0001);
        chk1(clk_keep_on_q, 1'h1);
        $display("test watchdog done");
        final_report();
    end
endmodule // wdit_timer_tb_top
